// ==== core/rtcc_pkg.sv ====
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package rtcc_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned TICK_NS = 3906250;
  localparam int unsigned TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned BUSY0_US = 244;
  localparam int unsigned BUSY1_US = 122;
  localparam int unsigned BUSY2_US = 61;
  localparam int unsigned BUSY0_CYC = BUSY0_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BUSY1_CYC = BUSY1_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BUSY2_CYC = BUSY2_US * 1000 / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // register offsets and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_IRQ = 12'h004;
  localparam logic [11:0] OFS_DIV = 12'h008;
  localparam logic [11:0] OFS_SEC = 12'h00c;
  localparam logic [11:0] OFS_MIN = 12'h010;
  localparam logic [11:0] OFS_HOUR = 12'h014;
  localparam logic [11:0] OFS_DAY = 12'h018;
  localparam logic [11:0] OFS_AMIN = 12'h020;
  localparam logic [11:0] OFS_AHOUR = 12'h024;
  localparam logic [11:0] OFS_ADAY = 12'h028;
  localparam logic [11:0] OFS_TEST = 12'h02c;
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_RST_BIT = 1;
  localparam int CTRL_BW_LSB = 5;
  localparam int IRQ_AF_BIT = 0;
  localparam int IRQ_PF_BIT = 1;
  localparam int IRQ_ALM_LSB = 2;
  localparam int IRQ_SRC_LSB = 5;
  localparam int TEST_EN_BIT = 0;
  localparam int TEST_MODE_LSB = 1;
  // ----------------------------------------------------------------
  // values
  // ----------------------------------------------------------------
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] SRC_32HZ = 3'h0;
  localparam logic [2:0] SRC_8HZ = 3'h1;
  localparam logic [2:0] SRC_2HZ = 3'h2;
  localparam logic [2:0] SRC_1HZ = 3'h3;
  localparam logic [2:0] SRC_MIN = 3'h4;
  localparam logic [2:0] SRC_HOUR = 3'h5;
  localparam logic [2:0] SRC_DAY = 3'h6;
  localparam logic [2:0] SRC_OFF = 3'h7;
  localparam logic [2:0] ALM_NONE = 3'h0;
  localparam logic [1:0] BW_RST = 2'h0;
  localparam logic [1:0] BW_122 = 2'h1;
  localparam logic [1:0] BW_61 = 2'h2;
  localparam logic [3:0] TEST_MODE_RST = 4'h0;
  localparam logic [3:0] TEST_DIVWR = 4'h0;
  localparam logic [7:0] MASK_32HZ = 8'h07;
  localparam logic [7:0] MASK_8HZ = 8'h1f;
  localparam logic [7:0] MASK_2HZ = 8'h7f;
  localparam logic [7:0] MASK_1HZ = 8'hff;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] day;
    logic [4:0] hour;
    logic [5:0] min;
    logic [5:0] sec;
  } rtcc_time_t;
  typedef struct packed {
    logic [2:0] src_sel;
    logic [2:0] alarm_en;
    logic pflag;
    logic aflag;
  } rtcc_irq_t;
  typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_BUSY = 2'h2} rtcc_busy_st_t;
endpackage

// ==== core/rtcc_tick.sv ====
`timescale 1ns/1ps
module rtcc_tick #(
  parameter int unsigned CYC = 781250
) (
  // clock
  input wire logic pclk,
  // control
  input wire logic run,
  input wire logic clr,
  // 256 Hz step
  output logic tick
);
  logic [19:0] cnt_q;

  // prescaler is not touched by system reset, only by clr
  assign tick = run & (cnt_q == 20'(CYC - 1));

  always_ff @(posedge pclk) begin
    if (clr) begin
      cnt_q <= 20'h00000;
    end else if (run) begin
      cnt_q <= tick ? 20'h00000 : cnt_q + 20'h00001;
    end
  end
endmodule

// ==== core/rtcc_modcnt.sv ====
`timescale 1ns/1ps
module rtcc_modcnt #(
  parameter int unsigned W = 6,
  parameter logic [W-1:0] MAX = '1
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // count and load
  input wire logic inc,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  // state
  output logic [W-1:0] value,
  output logic wrap
);
  logic [W-1:0] value_q;

  function automatic logic [W-1:0] clamp(input logic [W-1:0] v);
    clamp = (v > MAX) ? '0 : v;
  endfunction

  assign value = value_q;
  assign wrap = inc & (value_q == MAX);

  always_ff @(posedge pclk) begin
    if (wr) begin
      value_q <= clamp(wdata);
    end else if (wrap) begin
      value_q <= '0;
    end else if (inc) begin
      value_q <= value_q + 1'b1;
    end
  end

  AST_WR_CLAMP: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr && (wdata > MAX) |=> value == '0)
    else $error("out of range write did not load zero");

  AST_WRAP_ZERO: assert property (
    @(posedge pclk) disable iff (!presetn)
    inc && !wr && (value == MAX) |-> wrap ##1 (value == '0))
    else $error("counter did not wrap to zero");
endmodule

// ==== core/rtcc_core.sv ====
`timescale 1ns/1ps
module rtcc_core
  import rtcc_pkg::*;
#(
  parameter int unsigned P_TICK_CYC = TICK_CYC,
  parameter int unsigned P_BUSY0_CYC = BUSY0_CYC,
  parameter int unsigned P_BUSY1_CYC = BUSY1_CYC,
  parameter int unsigned P_BUSY2_CYC = BUSY2_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt controller
  output logic irq
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic setup_ph;
  logic acc_ph;
  logic hit_ctrl;
  logic hit_irq;
  logic hit_div;
  logic hit_sec;
  logic hit_min;
  logic hit_hour;
  logic hit_day;
  logic hit_amin;
  logic hit_ahour;
  logic hit_aday;
  logic hit_test;
  logic mapped;
  logic refused;
  logic acc_err;
  logic wr_ok;
  logic run_q;
  logic [1:0] bw_q;
  logic cnt_rst;
  logic tick;
  logic [7:0] div_q;
  logic sec_inc;
  logic sec_wrap;
  logic min_wrap;
  logic hour_wrap;
  logic [5:0] sec_v;
  logic [5:0] min_v;
  logic [4:0] hour_v;
  logic [15:0] day_q;
  rtcc_time_t time_s;
  logic [5:0] amin_q;
  logic [4:0] ahour_q;
  logic [8:0] aday_q;
  rtcc_irq_t irq_q;
  logic per_carry;
  logic min_hit;
  logic hour_hit;
  logic day_hit;
  logic alarm_match;
  logic [3:0] test_mode_q;
  logic test_en_q;
  logic test_act_q;
  logic test_divwr;
  rtcc_busy_st_t st_q;
  rtcc_busy_st_t st_d;
  logic [15:0] bcnt_q;
  logic [15:0] bcnt_d;
  logic [15:0] busy_len;
  logic busy;
  logic [31:0] rd_word;
  logic [31:0] prdata_q;

  function automatic logic stage_carry(input logic [7:0] d, input logic [7:0] m);
    stage_carry = (d & m) == m;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup_ph = psel & ~penable;
  assign acc_ph = psel & penable;
  assign hit_ctrl = paddr == OFS_CTRL;
  assign hit_irq = paddr == OFS_IRQ;
  assign hit_div = paddr == OFS_DIV;
  assign hit_sec = paddr == OFS_SEC;
  assign hit_min = paddr == OFS_MIN;
  assign hit_hour = paddr == OFS_HOUR;
  assign hit_day = paddr == OFS_DAY;
  assign hit_amin = paddr == OFS_AMIN;
  assign hit_ahour = paddr == OFS_AHOUR;
  assign hit_aday = paddr == OFS_ADAY;
  assign hit_test = paddr == OFS_TEST;
  assign mapped = hit_ctrl | hit_irq | hit_div | hit_sec | hit_min | hit_hour
                | hit_day | hit_amin | hit_ahour | hit_aday | hit_test;
  assign refused = busy & ~hit_ctrl;
  assign acc_err = ~mapped | refused;
  assign wr_ok = acc_ph & pwrite & ~acc_err;
  assign pready = 1'b1;
  assign pslverr = acc_ph & acc_err;

  // ----------------------------------------------------------------
  // run/stop control
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q <= 1'b0;
      bw_q <= BW_RST;
    end else if (wr_ok & hit_ctrl) begin
      run_q <= pwdata[CTRL_RUN_BIT];
      bw_q <= pwdata[CTRL_BW_LSB +: 2];
    end
  end

  assign cnt_rst = wr_ok & hit_ctrl & pwdata[CTRL_RST_BIT] & ~pwdata[CTRL_RUN_BIT];

  rtcc_tick #(
    .CYC(P_TICK_CYC)
  ) u_tick (
    .pclk(pclk),
    .run(run_q),
    .clr(cnt_rst),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // divider stages, 128 Hz in bit 0 up to 1 Hz in bit 7
  // ----------------------------------------------------------------
  // divider write mode
  assign test_divwr = test_act_q & (test_mode_q == TEST_DIVWR);

  always_ff @(posedge pclk) begin
    if (cnt_rst) begin
      div_q <= 8'h00;
    end else if (wr_ok & hit_div & test_divwr) begin
      div_q <= pwdata[7:0];
    end else if (tick) begin
      div_q <= div_q + 8'h01;
    end
  end

  assign sec_inc = tick & stage_carry(div_q, MASK_1HZ);

  // ----------------------------------------------------------------
  // time counters
  // ----------------------------------------------------------------
  // seconds counter
  rtcc_modcnt #(
    .W(6),
    .MAX(SEC_MAX)
  ) u_sec (
    .pclk(pclk),
    .presetn(presetn),
    .inc(sec_inc),
    .wr(wr_ok & hit_sec),
    .wdata(pwdata[5:0]),
    .value(sec_v),
    .wrap(sec_wrap)
  );

  rtcc_modcnt #(
    .W(6),
    .MAX(MIN_MAX)
  ) u_min (
    .pclk(pclk),
    .presetn(presetn),
    .inc(sec_wrap),
    .wr(wr_ok & hit_min),
    .wdata(pwdata[5:0]),
    .value(min_v),
    .wrap(min_wrap)
  );

  rtcc_modcnt #(
    .W(5),
    .MAX(HOUR_MAX)
  ) u_hour (
    .pclk(pclk),
    .presetn(presetn),
    .inc(min_wrap),
    .wr(wr_ok & hit_hour),
    .wdata(pwdata[4:0]),
    .value(hour_v),
    .wrap(hour_wrap)
  );

  always_ff @(posedge pclk) begin
    if (wr_ok & hit_day) begin
      day_q <= pwdata[15:0];
    end else if (hour_wrap) begin
      day_q <= day_q + 16'h0001;
    end
  end

  assign time_s = '{day: day_q, hour: hour_v, min: min_v, sec: sec_v};

  // ----------------------------------------------------------------
  // alarm compare values, kept as written
  // ----------------------------------------------------------------
  // no system reset
  always_ff @(posedge pclk) begin
    if (wr_ok & hit_amin) begin
      amin_q <= pwdata[5:0];
    end
    if (wr_ok & hit_ahour) begin
      ahour_q <= pwdata[4:0];
    end
    if (wr_ok & hit_aday) begin
      aday_q <= pwdata[8:0];
    end
  end

  assign min_hit = (time_s.min == amin_q) & (amin_q <= MIN_MAX);
  assign hour_hit = (time_s.hour == ahour_q) & (ahour_q <= HOUR_MAX);
  assign day_hit = time_s.day == {7'h00, aday_q};
  assign alarm_match = |(irq_q.alarm_en & {day_hit, hour_hit, min_hit});

  // ----------------------------------------------------------------
  // periodic source
  // ----------------------------------------------------------------
  // source select
  always_comb begin
    per_carry = 1'b0;
    unique case (irq_q.src_sel)
      SRC_32HZ: per_carry = tick & stage_carry(div_q, MASK_32HZ);
      SRC_8HZ: per_carry = tick & stage_carry(div_q, MASK_8HZ);
      SRC_2HZ: per_carry = tick & stage_carry(div_q, MASK_2HZ);
      SRC_1HZ: per_carry = sec_inc;
      SRC_MIN: per_carry = sec_wrap;
      SRC_HOUR: per_carry = min_wrap;
      SRC_DAY: per_carry = hour_wrap;
      SRC_OFF: per_carry = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // interrupt settings and pending flags
  // ----------------------------------------------------------------
  // reset select off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= '{src_sel: SRC_OFF, alarm_en: ALM_NONE, pflag: 1'b0, aflag: 1'b0};
    end else begin
      if (wr_ok & hit_irq) begin
        irq_q.src_sel <= pwdata[IRQ_SRC_LSB +: 3];
        irq_q.alarm_en <= pwdata[IRQ_ALM_LSB +: 3];
      end
      irq_q.pflag <= per_carry | (irq_q.pflag & ~(wr_ok & hit_irq & pwdata[IRQ_PF_BIT]));
      irq_q.aflag <= alarm_match | (irq_q.aflag & ~(wr_ok & hit_irq & pwdata[IRQ_AF_BIT]));
    end
  end

  assign irq = irq_q.pflag | irq_q.aflag;

  // ----------------------------------------------------------------
  // test register
  // ----------------------------------------------------------------
  // one then zero written to the enable bit enters test mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_mode_q <= TEST_MODE_RST;
      test_en_q <= 1'b0;
      test_act_q <= 1'b0;
    end else if (wr_ok & hit_test) begin
      test_mode_q <= pwdata[TEST_MODE_LSB +: 4];
      test_en_q <= pwdata[TEST_EN_BIT];
      test_act_q <= test_en_q & ~pwdata[TEST_EN_BIT];
    end
  end

  // ----------------------------------------------------------------
  // update busy window after each second step
  // ----------------------------------------------------------------
  assign busy_len = (bw_q == BW_122) ? 16'(P_BUSY1_CYC)
                  : (bw_q == BW_61) ? 16'(P_BUSY2_CYC) : 16'(P_BUSY0_CYC);
  assign busy = st_q == ST_BUSY;

  always_comb begin
    st_d = st_q;
    bcnt_d = bcnt_q;
    unique case (st_q)
      ST_IDLE: begin
        if (sec_inc) begin
          st_d = ST_BUSY;
          bcnt_d = busy_len;
        end
      end
      ST_BUSY: begin
        bcnt_d = bcnt_q - 16'h0001;
        if (bcnt_q <= 16'h0001) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_IDLE;
      bcnt_q <= 16'h0000;
    end else begin
      st_q <= st_d;
      bcnt_q <= bcnt_d;
    end
  end

  // ----------------------------------------------------------------
  // read data, sampled in the setup phase
  // ----------------------------------------------------------------
  // register read view
  assign rd_word = ({32{hit_ctrl}} & {24'h000000, busy, bw_q, 4'h0, run_q})
                 | ({32{hit_irq}} & {24'h000000, irq_q})
                 | ({32{hit_div}} & {24'h000000, div_q})
                 | ({32{hit_sec}} & {26'h0000000, time_s.sec})
                 | ({32{hit_min}} & {26'h0000000, time_s.min})
                 | ({32{hit_hour}} & {27'h0000000, time_s.hour})
                 | ({32{hit_day}} & {16'h0000, time_s.day})
                 | ({32{hit_amin}} & {26'h0000000, amin_q})
                 | ({32{hit_ahour}} & {27'h0000000, ahour_q})
                 | ({32{hit_aday}} & {23'h000000, aday_q})
                 | ({32{hit_test}} & {27'h0000000, test_mode_q, test_en_q});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (setup_ph) begin
      prdata_q <= (pwrite | refused) ? 32'h00000000 : rd_word;
    end
  end

  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // select after reset
  AST_SRC_RST: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> (irq_q.src_sel == SRC_OFF) && (irq_q.alarm_en == ALM_NONE))
    else $error("interrupt settings not at reset values");

  AST_PER_SET: assert property (
    @(posedge pclk) disable iff (!presetn)
    per_carry |=> irq_q.pflag && irq)
    else $error("periodic carry did not raise the flag");

  AST_PF_CLR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ok && hit_irq && pwdata[IRQ_PF_BIT] && !per_carry |=> !irq_q.pflag)
    else $error("periodic flag not cleared by write");

  AST_ALM_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    alarm_match && $past(alarm_match) |=> irq_q.aflag)
    else $error("alarm flag dropped while match stands");

  AST_AF_CLR: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ok && hit_irq && pwdata[IRQ_AF_BIT] && !alarm_match |=> !irq_q.aflag)
    else $error("alarm flag not cleared by write");

  AST_IRQ_CAUSE: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(irq) |-> $past(per_carry) || $past(alarm_match))
    else $error("interrupt rose with no event");

  AST_DIV_CLR: assert property (
    @(posedge pclk) disable iff (!presetn)
    cnt_rst |=> (div_q == 8'h00) && !tick)
    else $error("divider not cleared by counter reset");

  AST_DIV_IGN: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ok && hit_div && !test_divwr && !tick && !cnt_rst |=> $stable(div_q))
    else $error("divider took a write outside test mode");

  AST_BUSY_REFUSE: assert property (
    @(posedge pclk) disable iff (!presetn)
    sec_inc && !busy |=> busy && (!(acc_ph && !hit_ctrl) || pslverr))
    else $error("access not refused during update");

  AST_DAY_INC: assert property (
    @(posedge pclk) disable iff (!presetn)
    hour_wrap && !(wr_ok && hit_day) |=> day_q == $past(day_q) + 16'h0001)
    else $error("day counter did not advance on hour carry");
endmodule

// ==== sim/test_rtc_counters_alarms_irq.sv ====
`timescale 1ns/1ps
module test_rtc_counters_alarms_irq import rtcc_pkg::*;;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] r;
  logic [31:0] d1;
  logic e;
  logic [11:0] wa [11] = '{OFS_SEC, OFS_SEC, OFS_MIN, OFS_MIN, OFS_HOUR, OFS_HOUR, OFS_DAY, OFS_DAY,
                           OFS_AMIN, OFS_AHOUR, OFS_ADAY};
  logic [15:0] wv [11] = '{16'h3c, 16'h3b, 16'h40, 16'h3b, 16'h18, 16'h17, 16'hffff, 16'h5, 16'h3f,
                           16'h1f, 16'h1ff};
  logic [15:0] wx [11] = '{16'h0, 16'h3b, 16'h0, 16'h3b, 16'h0, 16'h17, 16'hffff, 16'h5, 16'h3f,
                           16'h1f, 16'h1ff};
  logic [5:0] am [7] = '{6'h00, 6'h3c, 6'h3c, 6'h3c, 6'h3c, 6'h3c, 6'h00};
  logic [4:0] ah [7] = '{5'h1f, 5'h1f, 5'h00, 5'h18, 5'h18, 5'h18, 5'h00};
  logic [8:0] ad [7] = '{9'h000, 9'h000, 9'h000, 9'h000, 9'h106, 9'h006, 9'h106};
  logic [2:0] en [7] = '{3'h1, 3'h1, 3'h2, 3'h2, 3'h4, 3'h4, 3'h0};
  logic [6:0] af = 7'h55;

  always #2.5 pclk = ~pclk;

  rtcc_core #(.P_TICK_CYC(4), .P_BUSY0_CYC(20), .P_BUSY1_CYC(10), .P_BUSY2_CYC(5)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq)
  );

  // ----------------------------------------------------------------
  // bus and check tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (fail_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    cmp(r, x);
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_IRQ, 32'he0);
    cmp(irq, 32'h0);
    rd(12'h01c, 32'h0);
    cmp(e, 32'h1);
    wr(OFS_CTRL, 32'h02);
    rd(OFS_DIV, 32'h0);
    wr(OFS_DIV, 32'h55);
    rd(OFS_DIV, 32'h0);
    wr(OFS_TEST, 32'h01);
    wr(OFS_TEST, 32'h00);
    wr(OFS_DIV, 32'h55);
    rd(OFS_DIV, 32'h55);
    wr(OFS_TEST, 32'h00);
    wr(OFS_CTRL, 32'h02);
    for (int i = 0; i < 11; i++) begin
      wr(wa[i], {16'h0, wv[i]});
      rd(wa[i], {16'h0, wx[i]});
    end
    // running: divider steps and periodic carries
    wr(OFS_CTRL, 32'h21);
    apb(1'b0, OFS_DIV, 32'h0);
    d1 = r;
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_DIV, 32'h0);
    cmp(32'((r - d1) inside {[32'h9:32'hc]}), 32'h1);
    for (int c = 0; c < 3; c++) begin
      wr(OFS_IRQ, {24'h0, 3'(c), 5'h03});
      repeat ((32 << (2 * c)) + 8) @(posedge pclk);
      rd(OFS_IRQ, {24'h0, 3'(c), 5'h02});
      cmp(irq, 32'h1);
    end
    // first seconds step cascades into the day counter
    wr(OFS_IRQ, 32'hc3);
    r = 32'h0;
    for (int i = 0; i < 500 && r[7] !== 1'b1; i++) begin
      apb(1'b0, OFS_CTRL, 32'h0);
    end
    rd(OFS_SEC, 32'h0);
    cmp(e, 32'h1);
    wr(OFS_CTRL, 32'h00);
    repeat (25) @(posedge pclk);
    apb(1'b0, OFS_DIV, 32'h0);
    d1 = r;
    rd(OFS_DIV, d1);
    rd(OFS_SEC, 32'h0);
    rd(OFS_MIN, 32'h0);
    rd(OFS_HOUR, 32'h0);
    rd(OFS_DAY, 32'h6);
    rd(OFS_IRQ, 32'hc2);
    wr(OFS_IRQ, 32'hc0);
    rd(OFS_IRQ, 32'hc2);
    wr(OFS_IRQ, 32'hc2);
    rd(OFS_IRQ, 32'hc0);
    cmp(irq, 32'h0);
    // second, minute and hour carries as the periodic source
    for (int s = 3; s < 6; s++) begin
      wr(OFS_CTRL, 32'h02);
      wr(OFS_SEC, 32'h3b);
      wr(OFS_MIN, 32'h3b);
      wr(OFS_HOUR, 32'h17);
      wr(OFS_IRQ, {24'h0, 3'(s), 5'h03});
      wr(OFS_CTRL, 32'h41);
      repeat (1100) @(posedge pclk);
      rd(OFS_IRQ, {24'h0, 3'(s), 5'h02});
      cmp(irq, 32'h1);
    end
    wr(OFS_CTRL, 32'h00);
    // alarm matches against stopped counters
    wr(OFS_DAY, 32'h106);
    for (int i = 0; i < 7; i++) begin
      wr(OFS_AMIN, {26'h0, am[i]});
      wr(OFS_AHOUR, {27'h0, ah[i]});
      wr(OFS_ADAY, {23'h0, ad[i]});
      wr(OFS_IRQ, {24'h0, 3'h7, en[i], 2'h3});
      rd(OFS_IRQ, {24'h0, 3'h7, en[i], 1'b0, af[i]});
      cmp(irq, {31'h0, af[i]});
    end
    wr(OFS_IRQ, 32'h03);
    rd(OFS_IRQ, 32'h00);
    cmp(irq, 32'h0);
    wr(OFS_IRQ, 32'h1c);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_IRQ, 32'he0);
    cmp(irq, 32'h0);
    rd(OFS_DAY, 32'h106);
    rd(OFS_ADAY, 32'h106);
    finish_test();
  end
endmodule
